/* rtl/rf_delay_pkg.sv */
/*
 * Shared constants for the radio turnaround and preamble configuration block:
 * register indices, field positions, values after reset, timing and states.
 * Assumes a single 100 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
// Function
// - Wait programmed steps before TX path power-down
// - Insert programmed delay on TX to RX
// - Insert low-field delay on RX to TX
// - Field value two gives standard eight symbols
package rf_delay_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing.

    // System clock period in nanoseconds.
    localparam int CLK_PERIOD_NS     = 10;
    // One delay step in microseconds.
    localparam int DELAY_STEP_US     = 16;
    // Clock cycles in one delay step, rounded up to whole cycles.
    localparam int DELAY_STEP_CYCLES = (DELAY_STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map: indices; the byte address is four times the index.

    localparam int             AXI_ADDR_W       = 16;
    localparam logic [13:0]    IDX_TX_FRAME_FMT = 14'h2215;
    localparam logic [13:0]    IDX_TX_OFF_DELAY = 14'h2216;
    localparam logic [13:0]    IDX_TURNAROUND   = 14'h2217;
    localparam logic [13:0]    IDX_RADIO_STATUS = 14'h2218;
    localparam logic [13:0]    IDX_GAIN_CFG_3   = 14'h2223;

    // Field positions inside the 8-bit registers.
    localparam int             FLD_HI_LSB       = 4;
    localparam int             FLD_LO_LSB       = 0;
    localparam int             FLD_W            = 4;

    // Values after reset.
    localparam logic [7:0]     RST_TX_FRAME_FMT = 8'h02;
    localparam logic [7:0]     RST_TX_OFF_DELAY = 8'h4F;
    localparam logic [7:0]     RST_TURNAROUND   = 8'h73;
    localparam logic [7:0]     RST_GAIN_CFG_3   = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Preamble.

    // Symbols added to the programmed preamble field.
    localparam logic [4:0]     PREAMBLE_BASE    = 5'h06;
    // Field value that yields the standard eight-symbol preamble.
    localparam logic [3:0]     PREAMBLE_STD_VAL = 4'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus responses and radio states.

    localparam logic [1:0]     RESP_OKAY        = 2'b00;
    localparam logic [1:0]     RESP_SLVERR      = 2'b10;

    // Radio states, Gray coded along off, TX, tail, TX-to-RX, RX, RX-to-TX.
    typedef enum logic [2:0] {
        ST_OFF     = 3'b000,
        ST_TX      = 3'b001,
        ST_TX_TAIL = 3'b011,
        ST_TX2RX   = 3'b010,
        ST_RX      = 3'b110,
        ST_RX2TX   = 3'b111
    } radio_state_e;

    // Register index of a byte address.
    function automatic logic [13:0] index_of(input logic [AXI_ADDR_W-1:0] addr);
        index_of = addr[AXI_ADDR_W-1:2];
    endfunction : index_of

endpackage : rf_delay_pkg

/* rtl/step_delay_timer.sv */
/*
 * Delay timer counting whole steps of UNIT_CYCLES clock cycles.
 * Assumes start_in is a one-cycle pulse and units_in is stable with it.
 */
module step_delay_timer
    import rf_delay_pkg::*;
#(
    parameter int UNIT_CYCLES = DELAY_STEP_CYCLES,
    parameter int UNITS_W     = FLD_W
) (
    // Clock and reset.
    input  wire logic               clk_in,
    input  wire logic               reset_n_in,
    // Control.
    input  wire logic               start_in,
    input  wire logic [UNITS_W-1:0] units_in,
    // Status.
    output logic                    busy_out,
    output logic                    done_out
);

    localparam int PRE_W = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;

    logic [PRE_W-1:0]   pre_cnt_reg;    // Cycles inside the current step.
    logic [UNITS_W-1:0] units_left_reg; // Steps still to run.

    wire step_end   = (pre_cnt_reg == PRE_W'(UNIT_CYCLES - 1));
    wire last_unit  = (units_left_reg == UNITS_W'(1));
    wire zero_units = (units_in == '0);

    // The step divider restarts at every start, so a delay is exact to the cycle
    // instead of depending on the phase of a free-running tick.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pre_cnt_reg    <= '0;
            units_left_reg <= '0;
            busy_out       <= 1'b0;
            done_out       <= 1'b0;
        end else if (start_in) begin
            pre_cnt_reg    <= '0;
            units_left_reg <= units_in;
            busy_out       <= !zero_units;
            done_out       <= zero_units;
        end else if (busy_out && step_end) begin
            pre_cnt_reg    <= '0;
            units_left_reg <= units_left_reg - UNITS_W'(1);
            busy_out       <= !last_unit;
            done_out       <= last_unit;
        end else begin
            pre_cnt_reg    <= busy_out ? pre_cnt_reg + PRE_W'(1) : '0;
            done_out       <= 1'b0;
        end
    end

endmodule : step_delay_timer

/* rtl/rf_state_delay_preamble_cfg.sv */
/*
 * Radio state sequencing with programmable power-down and turnaround delays,
 * transmit preamble length control, and an AXI4-Lite register slave.
 * Assumes all inputs are synchronous to clk_in and event inputs are pulses.
 */
// Decided for this implementation: register access over AXI4-Lite.
module rf_state_delay_preamble_cfg
    import rf_delay_pkg::*;
#(
    parameter int UNIT_CYCLES = DELAY_STEP_CYCLES
) (
    // Clock and reset.
    input  wire logic                  clk_in,
    input  wire logic                  reset_n_in,
    // AXI4-Lite write address.
    input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic                  s_axi_awvalid_in,
    output logic                       s_axi_awready_out,
    // AXI4-Lite write data.
    input  wire logic [31:0]           s_axi_wdata_in,
    input  wire logic [3:0]            s_axi_wstrb_in,
    input  wire logic                  s_axi_wvalid_in,
    output logic                       s_axi_wready_out,
    // AXI4-Lite write response.
    output logic [1:0]                 s_axi_bresp_out,
    output logic                       s_axi_bvalid_out,
    input  wire logic                  s_axi_bready_in,
    // AXI4-Lite read address.
    input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic                  s_axi_arvalid_in,
    output logic                       s_axi_arready_out,
    // AXI4-Lite read data.
    output logic [31:0]                s_axi_rdata_out,
    output logic [1:0]                 s_axi_rresp_out,
    output logic                       s_axi_rvalid_out,
    input  wire logic                  s_axi_rready_in,
    // Radio sequencing requests.
    input  wire logic                  tx_start_in,
    input  wire logic                  rx_start_in,
    input  wire logic                  tx_packet_done_in,
    input  wire logic                  radio_stop_in,
    // Preamble generation.
    input  wire logic                  preamble_start_in,
    input  wire logic                  symbol_tick_in,
    // Radio path controls.
    output logic                       tx_path_on_out,
    output logic                       rx_path_on_out,
    output logic                       turnaround_out,
    // Preamble status.
    output logic [4:0]                 tx_preamble_symbols_out,
    output logic                       tx_preamble_std_out,
    output logic                       preamble_active_out,
    output logic                       preamble_done_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [7:0]   tx_frame_fmt_reg;   // Holds the transmit preamble field.
    logic [7:0]   tx_off_delay_reg;   // Holds the TX path power-down delay.
    logic [7:0]   turnaround_reg;     // Holds both turnaround delays.
    logic [7:0]   gain_cfg_3_reg;     // Plain storage for the gain setting.
    radio_state_e state_reg;          // Current radio state.
    radio_state_e state_next;         // State for the next cycle.

    // Fields of the configuration registers.
    wire [3:0] tx_path_off_delay = tx_off_delay_reg[FLD_HI_LSB +: FLD_W];
    wire [3:0] tx_to_rx_delay    = turnaround_reg[FLD_HI_LSB +: FLD_W];
    wire [3:0] rx_to_tx_delay    = turnaround_reg[FLD_LO_LSB +: FLD_W];
    wire [3:0] tx_preamble_len   = tx_frame_fmt_reg[FLD_LO_LSB +: FLD_W];

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel.

    logic [AXI_ADDR_W-1:0] wr_addr_reg;   // Captured write address.
    logic [7:0]            wr_data_reg;   // Captured low data byte.
    logic                  wr_strb_reg;   // Captured low byte enable.
    logic                  aw_held_reg;   // Write address captured.
    logic                  w_held_reg;    // Write data captured.

    wire aw_take  = s_axi_awvalid_in && s_axi_awready_out;
    wire w_take   = s_axi_wvalid_in && s_axi_wready_out;
    wire wr_fire  = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
    wire [13:0] wr_idx = index_of(wr_addr_reg);
    wire wr_hit_frame = (wr_idx == IDX_TX_FRAME_FMT);
    wire wr_hit_off   = (wr_idx == IDX_TX_OFF_DELAY);
    wire wr_hit_turn  = (wr_idx == IDX_TURNAROUND);
    wire wr_hit_gain  = (wr_idx == IDX_GAIN_CFG_3);
    wire wr_hit_stat  = (wr_idx == IDX_RADIO_STATUS);
    wire wr_mapped    = wr_hit_frame || wr_hit_off || wr_hit_turn || wr_hit_gain
                        || wr_hit_stat;
    wire wr_store     = wr_fire && wr_strb_reg;

    // Address and data are taken apart, in either order; the
    // response waits for both.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            wr_addr_reg <= '0;
            wr_data_reg <= '0;
            wr_strb_reg <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                wr_addr_reg <= s_axi_awaddr_in;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (w_take) begin
                w_held_reg  <= 1'b1;
                wr_data_reg <= s_axi_wdata_in[7:0];
                wr_strb_reg <= s_axi_wstrb_in[0];
            end else if (wr_fire) begin
                w_held_reg  <= 1'b0;
            end
        end
    end

    // Ready is low while a beat is held, so no second write can overtake.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= RESP_OKAY;
        end else begin
            s_axi_awready_out <= !aw_held_reg && !aw_take && !s_axi_bvalid_out;
            s_axi_wready_out  <= !w_held_reg && !w_take && !s_axi_bvalid_out;
            if (wr_fire) begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    // Configuration storage; the status register ignores writes.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_frame_fmt_reg <= RST_TX_FRAME_FMT;
            tx_off_delay_reg <= RST_TX_OFF_DELAY;
            turnaround_reg   <= RST_TURNAROUND;
            gain_cfg_3_reg   <= RST_GAIN_CFG_3;
        end else if (wr_store) begin
            if (wr_hit_frame) begin
                tx_frame_fmt_reg <= wr_data_reg;
            end
            if (wr_hit_off) begin
                tx_off_delay_reg <= wr_data_reg;
            end
            if (wr_hit_turn) begin
                turnaround_reg <= wr_data_reg;
            end
            if (wr_hit_gain) begin
                gain_cfg_3_reg <= wr_data_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel.

    logic       timer_busy;                // Delay timer running.
    logic       timer_done;                // Delay timer expired.
    wire        ar_take = s_axi_arvalid_in && s_axi_arready_out;
    wire [13:0] rd_idx  = index_of(s_axi_araddr_in);
    wire        rd_hit_frame = (rd_idx == IDX_TX_FRAME_FMT);
    wire        rd_hit_off   = (rd_idx == IDX_TX_OFF_DELAY);
    wire        rd_hit_turn  = (rd_idx == IDX_TURNAROUND);
    wire        rd_hit_gain  = (rd_idx == IDX_GAIN_CFG_3);
    wire        rd_hit_stat  = (rd_idx == IDX_RADIO_STATUS);
    wire        rd_mapped    = rd_hit_frame || rd_hit_off || rd_hit_turn || rd_hit_gain
                               || rd_hit_stat;
    // Status shows the live state, timer and preamble activity.
    wire [7:0]  status_byte  = {3'b000, preamble_active_out, timer_busy, state_reg};
    wire [7:0]  rd_byte      = rd_hit_frame ? tx_frame_fmt_reg :
                               rd_hit_off   ? tx_off_delay_reg :
                               rd_hit_turn  ? turnaround_reg   :
                               rd_hit_gain  ? gain_cfg_3_reg   :
                               rd_hit_stat  ? status_byte      : 8'h00;

    // One read at a time; data are captured when the address is taken.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= '0;
            s_axi_rresp_out   <= RESP_OKAY;
        end else begin
            s_axi_arready_out <= !s_axi_rvalid_out && !ar_take;
            if (ar_take) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out  <= {24'h0000_00, rd_byte};
                s_axi_rresp_out  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Radio state sequencing.

    // Next state: stop wins, then the requests, then timer expiry.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (tx_start_in) begin
                    state_next = ST_TX;
                end else if (rx_start_in) begin
                    state_next = ST_RX;
                end
            end
            ST_TX: begin
                if (rx_start_in) begin
                    state_next = ST_TX2RX;
                end else if (tx_packet_done_in) begin
                    state_next = ST_TX_TAIL;
                end
            end
            ST_TX_TAIL: begin
                if (rx_start_in) begin
                    state_next = ST_TX2RX;
                end else if (tx_start_in) begin
                    state_next = ST_TX;
                end else if (timer_done) begin
                    state_next = ST_OFF;
                end
            end
            ST_TX2RX: begin
                if (timer_done) begin
                    state_next = ST_RX;
                end
            end
            ST_RX: begin
                if (tx_start_in) begin
                    state_next = ST_RX2TX;
                end
            end
            ST_RX2TX: begin
                if (timer_done) begin
                    state_next = ST_TX;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        if (radio_stop_in) begin
            state_next = ST_OFF;
        end
    end

    // A delay starts on entry to a waiting state; one timer is enough because
    // only one delay can run at a time.
    wire       enter_wait  = (state_next != state_reg) && ((state_next == ST_TX_TAIL)
                             || (state_next == ST_TX2RX) || (state_next == ST_RX2TX));
    wire [3:0] wait_units  = (state_next == ST_TX_TAIL) ? tx_path_off_delay :
                             (state_next == ST_TX2RX)   ? tx_to_rx_delay    :
                                                          rx_to_tx_delay;

    step_delay_timer #(
        .UNIT_CYCLES (UNIT_CYCLES),
        .UNITS_W     (FLD_W)
    ) u_timer (
        .clk_in      (clk_in),
        .reset_n_in  (reset_n_in),
        .start_in    (enter_wait),
        .units_in    (wait_units),
        .busy_out    (timer_busy),
        .done_out    (timer_done)
    );

    // State and path controls are registered so the outputs are glitch free.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg      <= ST_OFF;
            tx_path_on_out <= 1'b0;
            rx_path_on_out <= 1'b0;
            turnaround_out <= 1'b0;
        end else begin
            state_reg      <= state_next;
            tx_path_on_out <= (state_next == ST_TX) || (state_next == ST_TX_TAIL);
            rx_path_on_out <= (state_next == ST_RX);
            turnaround_out <= (state_next == ST_TX2RX) || (state_next == ST_RX2TX);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit preamble.

    logic [4:0] sym_left_reg;               // Preamble symbols still to send.
    wire  [4:0] preamble_symbols = {1'b0, tx_preamble_len} + PREAMBLE_BASE;

    // The length is caught at start, so a register write during a preamble
    // cannot shorten or stretch the one being sent.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sym_left_reg            <= '0;
            preamble_active_out     <= 1'b0;
            preamble_done_out       <= 1'b0;
            tx_preamble_symbols_out <= '0;
            tx_preamble_std_out     <= 1'b0;
        end else begin
            tx_preamble_symbols_out <= preamble_symbols;
            tx_preamble_std_out     <= (tx_preamble_len == PREAMBLE_STD_VAL);
            preamble_done_out       <= 1'b0;
            if (preamble_start_in) begin
                sym_left_reg        <= preamble_symbols;
                preamble_active_out <= 1'b1;
            end else if (preamble_active_out && symbol_tick_in) begin
                sym_left_reg        <= sym_left_reg - 5'h01;
                if (sym_left_reg == 5'h01) begin
                    preamble_active_out <= 1'b0;
                    preamble_done_out   <= 1'b1;
                end
            end
        end
    end

endmodule : rf_state_delay_preamble_cfg

/* testbench/rf_state_delay_preamble_cfg_props.sv */
/*
 * Checker for the radio delay and preamble block, watching top-level ports only.
 * Assumes it is bound to the top module with the same UNIT_CYCLES value.
 */
module rf_state_delay_preamble_cfg_props
    import rf_delay_pkg::*;
#(
    parameter int UNIT_CYCLES = DELAY_STEP_CYCLES
) (
    // Clock and reset.
    input wire logic       clk_in,
    input wire logic       reset_n_in,
    // Write response.
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic       s_axi_bvalid_out,
    input wire logic       s_axi_bready_in,
    // Radio sequencing.
    input wire logic       tx_start_in,
    input wire logic       radio_stop_in,
    input wire logic       tx_path_on_out,
    input wire logic       rx_path_on_out,
    input wire logic       turnaround_out,
    // Preamble.
    input wire logic [4:0] tx_preamble_symbols_out,
    input wire logic       tx_preamble_std_out,
    input wire logic       preamble_active_out,
    input wire logic       preamble_done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Longest turnaround is fifteen steps plus the exit edge.
    localparam int MAX_WAIT = 15 * UNIT_CYCLES + 1;
    logic [31:0] wait_reg;  // Cycles spent in the current turnaround.
    // No path and no turnaround means the radio is off.
    wire         idle = !tx_path_on_out && !rx_path_on_out && !turnaround_out;
    // The counter restarts whenever the turnaround ends, so a stuck timer shows up.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wait_reg <= 32'h0000_0000;
        end else begin
            wait_reg <= turnaround_out ? wait_reg + 32'h0000_0001 : 32'h0000_0000;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence done_pulse;
        preamble_done_out ##1 !preamble_done_out;
    endsequence
    sequence tx_request_when_off;
        idle && tx_start_in && !radio_stop_in;
    endsequence
    bresp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
        s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer not held");
    path_excl_a: assert property (!(tx_path_on_out && rx_path_on_out))
        else $error("both paths on");
    turn_quiet_a: assert property (turnaround_out |-> !tx_path_on_out
        && !rx_path_on_out) else $error("path on during turnaround");
    turn_bound_a: assert property (wait_reg <= MAX_WAIT)
        else $error("turnaround too long");
    tx_entry_a: assert property (tx_request_when_off |=> tx_path_on_out && !turnaround_out)
        else $error("transmit request from off not taken");
    stop_off_a: assert property (radio_stop_in |=> idle)
        else $error("stop did not turn the radio off");
    std_match_a: assert property (tx_preamble_std_out == (tx_preamble_symbols_out == 5'h08))
        else $error("standard flag disagrees with length");
    done_pulse_a: assert property (preamble_done_out |-> done_pulse)
        else $error("preamble done longer than one cycle");
    done_end_a: assert property ($rose(preamble_done_out) |->
        $past(preamble_active_out) && !preamble_active_out) else $error("done not at end");
endmodule : rf_state_delay_preamble_cfg_props

bind rf_state_delay_preamble_cfg rf_state_delay_preamble_cfg_props #(
    .UNIT_CYCLES(UNIT_CYCLES)
) u_rf_state_delay_preamble_cfg_props (.*);

/* testbench/tb_rf_state_delay_preamble_cfg.sv */
/*
 * Self-checking bench for the radio delay and preamble block.
 * Assumes the checker is bound separately; one delay step is cut to 4 cycles.
 */
module tb_rf_state_delay_preamble_cfg
    import rf_delay_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int U = 4;  // Short step keeps the delay runs brief.
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [5:0]  req = '0;  // Start, receive, packet done, stop, tick, preamble start.
    logic        awready, wready, bvalid, arready, rvalid, txon, rxon, turn, std, act, done;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [4:0]  syms;
    int          n_fail = 0;
    int          checks = 0;
    // Register model; status reads zero while idle.
    logic [7:0]  mdl[logic [15:0]] = '{16'h8854: 8'h02, 16'h8858: 8'h4F, 16'h885C: 8'h73,
                                       16'h8860: 8'h00, 16'h888C: 8'h00};
    always #5 clk = ~clk;
    rf_state_delay_preamble_cfg #(.UNIT_CYCLES(U)) u_rf_state_delay_preamble_cfg (
        .clk_in(clk), .reset_n_in(rst_n), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .tx_start_in(req[0]), .rx_start_in(req[1]),
        .tx_packet_done_in(req[2]), .radio_stop_in(req[3]), .symbol_tick_in(req[4]),
        .preamble_start_in(req[5]), .tx_path_on_out(txon), .rx_path_on_out(rxon),
        .turnaround_out(turn), .tx_preamble_symbols_out(syms), .tx_preamble_std_out(std),
        .preamble_active_out(act), .preamble_done_out(done));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Address, data and bready go together; bready drops after the answer.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        int t = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            t++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && t < 100);
        bready <= 1'b0;
        chk("bvalid", 1, bvalid);
        if (mdl.exists(a) && a != 16'h8860) mdl[a] = d;
        chk("bresp", mdl.exists(a) ? RESP_OKAY : RESP_SLVERR, bresp);
    endtask : wr
    task automatic rd(input logic [15:0] a);
        int t = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            t++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && t < 100);
        rready <= 1'b0;
        chk("rvalid", 1, rvalid);
        chk("rresp", mdl.exists(a) ? RESP_OKAY : RESP_SLVERR, rresp);
        chk("rdata", mdl.exists(a) ? {24'h00_0000, mdl[a]} : 32'h0000_0000, rdata);
    endtask : rd
    // One-cycle request pulse; returns at the edge that samples it.
    task automatic pulse(input int i);
        @(posedge clk);
        req[i] <= 1'b1;
        @(posedge clk);
        req[i] <= 1'b0;
    endtask : pulse
    // Edges until the path outputs {turnaround, rx, tx} show p, bounded.
    task automatic wait_path(input logic [2:0] p, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ({turn, rxon, txon} !== p && n < 5000);
    endtask : wait_path
    // Steps plus the exit edge; a zero field still spends one cycle waiting.
    function automatic int dly(input int v);
        return v * U + 1;
    endfunction : dly
    task automatic conclude();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////
    initial begin
        int n;
        logic [3:0] a, b, c;
        void'($urandom(32'hcd61_4add));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        foreach (mdl[k]) rd(k);
        wr(16'h8864, 8'hA5);
        rd(16'h8864);
        wr(16'h8860, 8'hFF);
        rd(16'h8860);
        wr(16'h888C, 8'($urandom));
        rd(16'h888C);
        // Both limits first, then random fields.
        for (int i = 0; i < 4; i++) begin
            {a, b, c} = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($urandom);
            wr(16'h8858, {a, 4'($urandom)});
            wr(16'h885C, {b, c});
            rd(16'h8858);
            rd(16'h885C);
            pulse(0);
            wait_path(3'b001, n);
            pulse(2);
            wait_path(3'b000, n);
            chk("off_delay", dly(a), n);
            pulse(0);
            wait_path(3'b001, n);
            pulse(1);
            wait_path(3'b010, n);
            chk("tx_rx_delay", dly(b), n);
            pulse(0);
            wait_path(3'b001, n);
            chk("rx_tx_delay", dly(c), n);
            pulse(3);
            wait_path(3'b000, n);
            chk("stop", 1, n);
        end
        // Every preamble field, with a full run of symbol ticks each.
        for (int k = 0; k < 16; k++) begin
            wr(16'h8854, {4'($urandom), 4'(k)});
            rd(16'h8854);
            chk("symbols", 5'(k) + 5'h06, syms);
            chk("std", k == 2, std);
            pulse(5);
            for (int j = 0; j < k + 6; j++) begin
                #1;
                chk("active", 1, act);
                pulse(4);
                #1;
                chk("done", j == k + 5, done);
            end
        end
        wr(16'h8854, 8'h02);
        conclude();
    end
    initial begin
        #500_000;
        n_fail++;
        conclude();
    end
endmodule : tb_rf_state_delay_preamble_cfg
